// ### itc_cfg.svh
// itc_cfg.svh: offsets, record fields, reset values of the transfer controller
// assumes inclusion by the controller top and its bench only
//
// Behaviour
// - enabled activation fetches record, then transfers data
// - vector table entry n at base plus 4n
// - short mode: 3-word records, low/high ranges
// - full mode: 4-word records, whole 4-Gbyte space
// - read skip reuses held record on repeat
// - normal, repeat, block modes with chain/sequence
// - chain walks consecutive records before ending
// - sequence reads record address from index table
// - per-source activation enable bits
// - status shows busy and current vector
// - software aborts chain, controls sequence transfer
// - starts activations only while module clock enabled
// - CPU interrupt per transfer or at end
`ifndef ITC_CFG_SVH
`define ITC_CFG_SVH
// ------------------------------
// register byte offsets
// ------------------------------
`define ITC_A_CTRL 8'h00
`define ITC_A_VBR  8'h04
`define ITC_A_IBR  8'h08
`define ITC_A_EN   8'h0c
`define ITC_A_STAT 8'h10
`define ITC_A_IST  8'h14
`define ITC_A_IMSK 8'h18
`define ITC_A_SEQ  8'h1c
// ------------------------------
// control bits
// ------------------------------
`define ITC_C_CLK  0
`define ITC_C_SHRT 1
`define ITC_C_SKIP 2
`define ITC_C_SEQ  3
`define ITC_C_CAB  4
`define ITC_C_SAB  5
// ------------------------------
// record word 0 fields
// ------------------------------
`define ITC_R_CHN  2
`define ITC_R_EACH 3
`define ITC_R_SINC 4
`define ITC_R_DINC 5
`define ITC_M_NORM 2'h0
`define ITC_M_REP  2'h1
`define ITC_M_BLK  2'h2
`define ITC_RST_CTRL 6'h00
`endif

// ### itc_pkg.sv
// itc_pkg.sv: engine state type of the transfer controller
// assumes nothing beyond itc_cfg.svh
`default_nettype none
package itc_pkg;
	typedef enum logic [7:0] {
		S_IDLE = 8'h01, // waiting for a request
		S_VEC  = 8'h02, // vector table read
		S_SEQ  = 8'h04, // index table read
		S_REC  = 8'h08, // record word reads
		S_RD   = 8'h10, // source read
		S_WR   = 8'h20, // destination write
		S_WB   = 8'h40, // record write back
		S_END  = 8'h80  // activation end
	} itc_state_t;
endpackage
`default_nettype wire

// ### itc_top.sv
// itc_top.sv: interrupt activated transfer controller, one clock
// assumes a memory slave that answers each request with a one-cycle ack
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "itc_cfg.svh"
module itc_top import itc_pkg::*; #(
	parameter int N = 8 // activation sources
) (
	input  wire logic         sys_clk,
	input  wire logic         rstn,
	input  wire logic [7:0]   reg_addr,
	input  wire logic [31:0]  reg_wdata,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	output logic      [31:0]  reg_rdata,
	input  wire logic [N-1:0] act_req,
	output logic              mem_req,
	output logic              mem_we,
	output logic      [31:0]  mem_addr,
	output logic      [31:0]  mem_wdata,
	input  wire logic [31:0]  mem_rdata,
	input  wire logic         mem_ack,
	output logic              irq
);
	// ------------------------------
	// state
	// ------------------------------
	logic [5:0]   ctrl_r, ctrl_nxt;   // control bits
	logic [31:0]  vbr_r, vbr_nxt;     // vector_table_base_register
	logic [31:0]  ibr_r, ibr_nxt;     // index_table_base_register
	logic [N-1:0] en_r, en_nxt;       // activation_enable_bits
	logic [1:0]   ist_r, ist_nxt;     // sticky events
	logic [1:0]   imsk_r, imsk_nxt;   // event mask
	logic [7:0]   seqn_r, seqn_nxt;   // sequence number
	logic [31:0]  rdat_r, rdat_nxt;   // read data
	logic         irq_r, irq_nxt;
	logic [N-1:0] pend_r, pend_nxt;   // waiting requests
	itc_state_t   st_r, st_nxt;
	logic [7:0]   vec_r, vec_nxt;     // vector in service
	logic [7:0]   last_r, last_nxt;   // vector of held record
	logic         hold_r, hold_nxt;   // held record usable
	logic         cab_r, cab_nxt;     // chain abort latched
	logic [31:0]  w_r [4];            // record words
	logic [31:0]  w_nxt [4];
	logic [31:0]  rec_r, rec_nxt;     // record address
	logic [1:0]   wi_r, wi_nxt;       // word index
	logic [7:0]   bc_r, bc_nxt;       // block words left
	logic [31:0]  dat_r, dat_nxt;     // data in flight
	logic         req_r, req_nxt;
	logic         we_r, we_nxt;
	logic [31:0]  adr_r, adr_nxt;
	logic [31:0]  wd_r, wd_nxt;
	logic         ev_x, ev_e;         // transfer and end events
	logic         dis;                // clear enable of vec_r
	logic         shrt;
	logic [1:0]   nw;                 // last word index
	logic [15:0]  cnt;
	logic [7:0]   blk;
	logic         pick;
	logic [7:0]   pv;

	// sign extension keeps short addresses in the two legal ranges
	function automatic logic [31:0] ea(input logic [31:0] a, input logic s);
		ea = s ? {{8{a[23]}}, a[23:0]} : a;
	endfunction

	assign shrt = ctrl_r[`ITC_C_SHRT];
	assign nw   = shrt ? 2'h2 : 2'h3;
	assign cnt  = w_r[0][31:16];
	assign blk  = shrt ? w_r[0][15:8] : w_r[3][7:0];

	// ------------------------------
	// registers
	// ------------------------------
	// software writes win over a hardware enable clear
	always_comb begin
		ctrl_nxt = ctrl_r;
		ctrl_nxt[`ITC_C_CAB] = 1'b0;
		ctrl_nxt[`ITC_C_SAB] = 1'b0;
		vbr_nxt  = vbr_r;
		ibr_nxt  = ibr_r;
		en_nxt   = en_r;
		imsk_nxt = imsk_r;
		seqn_nxt = seqn_r;
		rdat_nxt = 32'h0;
		if (dis && vec_r < N) begin
			en_nxt[vec_r[$clog2(N)-1:0]] = 1'b0;
		end
		// set wins over the write-one clear
		ist_nxt = ist_r & ~((reg_wr && reg_addr == `ITC_A_IST) ? reg_wdata[1:0] : 2'h0);
		ist_nxt = ist_nxt | {ev_e, ev_x};
		if (reg_wr) begin
			case (reg_addr)
				`ITC_A_CTRL: ctrl_nxt = reg_wdata[5:0];
				`ITC_A_VBR:  vbr_nxt  = {reg_wdata[31:10], 10'h0};
				`ITC_A_IBR:  ibr_nxt  = reg_wdata;
				`ITC_A_EN:   en_nxt   = reg_wdata[N-1:0];
				`ITC_A_IMSK: imsk_nxt = reg_wdata[1:0];
				`ITC_A_SEQ:  seqn_nxt = reg_wdata[7:0];
				default: ;
			endcase
		end
		if (ctrl_nxt[`ITC_C_SAB]) begin
			ctrl_nxt[`ITC_C_SEQ] = 1'b0;
		end
		if (reg_rd) begin
			case (reg_addr)
				`ITC_A_CTRL: rdat_nxt = {26'h0, ctrl_r};
				`ITC_A_VBR:  rdat_nxt = vbr_r;
				`ITC_A_IBR:  rdat_nxt = ibr_r;
				`ITC_A_EN:   rdat_nxt = {{(32-N){1'b0}}, en_r};
				`ITC_A_STAT: rdat_nxt = {st_r != S_IDLE, 23'h0, vec_r};
				`ITC_A_IST:  rdat_nxt = {30'h0, ist_r};
				`ITC_A_IMSK: rdat_nxt = {30'h0, imsk_r};
				`ITC_A_SEQ:  rdat_nxt = {24'h0, seqn_r};
				default:     rdat_nxt = 32'h0;
			endcase
		end
		irq_nxt = |(ist_nxt & imsk_r);
	end

	// register update
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ctrl_r <= `ITC_RST_CTRL;
			vbr_r  <= 32'h0;
			ibr_r  <= 32'h0;
			en_r   <= '0;
			ist_r  <= 2'h0;
			imsk_r <= 2'h0;
			seqn_r <= 8'h0;
			rdat_r <= 32'h0;
			irq_r  <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			vbr_r  <= vbr_nxt;
			ibr_r  <= ibr_nxt;
			en_r   <= en_nxt;
			ist_r  <= ist_nxt;
			imsk_r <= imsk_nxt;
			seqn_r <= seqn_nxt;
			rdat_r <= rdat_nxt;
			irq_r  <= irq_nxt;
		end
	end

	// ------------------------------
	// request priority
	// ------------------------------
	// lowest source number wins
	always_comb begin
		pick = 1'b0;
		pv   = 8'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (pend_r[i]) begin
				pick = 1'b1;
				pv   = 8'(i);
			end
		end
	end

	// ------------------------------
	// engine
	// ------------------------------
	always_comb begin
		st_nxt   = st_r;
		vec_nxt  = vec_r;
		last_nxt = last_r;
		hold_nxt = hold_r;
		rec_nxt  = rec_r;
		wi_nxt   = wi_r;
		bc_nxt   = bc_r;
		dat_nxt  = dat_r;
		adr_nxt  = adr_r;
		for (int k = 0; k < 4; k++) begin
			w_nxt[k] = w_r[k];
		end
		cab_nxt  = cab_r | ctrl_r[`ITC_C_CAB];
		ev_x     = 1'b0;
		ev_e     = 1'b0;
		dis      = 1'b0;
		// requests stay pending while busy
		pend_nxt = pend_r | (act_req & en_r);
		case (st_r)
			S_IDLE: begin
				cab_nxt = 1'b0;
				if (ctrl_r[`ITC_C_CLK] && pick) begin
					pend_nxt[pv[$clog2(N)-1:0]] = 1'b0;
					vec_nxt = pv;
					if (ctrl_r[`ITC_C_SEQ]) begin
						st_nxt  = S_SEQ;
						adr_nxt = ibr_r + {22'h0, seqn_r, 2'h0};
					end else if (ctrl_r[`ITC_C_SKIP] && hold_r && last_r == pv) begin
						st_nxt  = S_RD;
						adr_nxt = ea(w_r[1], shrt);
						bc_nxt  = (w_r[0][1:0] == `ITC_M_BLK) ? blk : 8'h1;
					end else begin
						st_nxt  = S_VEC;
						adr_nxt = vbr_r + {22'h0, pv, 2'h0};
					end
				end
			end
			S_VEC, S_SEQ: if (mem_ack) begin
				st_nxt   = S_REC;
				rec_nxt  = mem_rdata;
				adr_nxt  = mem_rdata;
				wi_nxt   = 2'h0;
				hold_nxt = 1'b0;
			end
			S_REC: if (mem_ack) begin
				w_nxt[wi_r] = mem_rdata;
				if (wi_r == nw) begin
					st_nxt  = S_RD;
					adr_nxt = ea(w_nxt[1], shrt);
					bc_nxt  = (w_nxt[0][1:0] == `ITC_M_BLK) ? (shrt ? w_nxt[0][15:8] :
						w_nxt[3][7:0]) : 8'h1;
				end else begin
					wi_nxt  = wi_r + 2'h1;
					adr_nxt = adr_r + 32'h4;
				end
			end
			S_RD: if (mem_ack) begin
				st_nxt  = S_WR;
				dat_nxt = mem_rdata;
				adr_nxt = ea(w_r[2], shrt);
			end
			S_WR: if (mem_ack) begin
				w_nxt[1] = w_r[1] + (w_r[0][`ITC_R_SINC] ? 32'h4 : 32'h0);
				w_nxt[2] = w_r[2] + (w_r[0][`ITC_R_DINC] ? 32'h4 : 32'h0);
				bc_nxt   = bc_r - 8'h1;
				if (bc_r == 8'h1) begin
					w_nxt[0][31:16] = cnt - 16'h1;
					ev_x = w_r[0][`ITC_R_EACH];
					if (cnt == 16'h1) begin
						if (w_r[0][1:0] == `ITC_M_REP) begin
							w_nxt[0][31:16] = {8'h0, blk};
						end else begin
							ev_x = 1'b1;
							dis  = 1'b1;
						end
					end
					st_nxt  = S_WB;
					wi_nxt  = 2'h0;
					adr_nxt = rec_r;
				end else begin
					st_nxt  = S_RD;
					adr_nxt = ea(w_nxt[1], shrt);
				end
			end
			S_WB: if (mem_ack) begin
				if (wi_r == nw) begin
					if (w_r[0][`ITC_R_CHN] && !cab_r) begin
						st_nxt  = S_REC;
						rec_nxt = rec_r + {28'h0, nw, 2'h0} + 32'h4;
						last_nxt = ~vec_r;                         // marks a chained walk
						adr_nxt = rec_nxt;
						wi_nxt  = 2'h0;
					end else begin
						st_nxt   = S_END;
						last_nxt = vec_r;
						// a walk that chained holds no record
						hold_nxt = (last_r != ~vec_r);
					end
				end else begin
					wi_nxt  = wi_r + 2'h1;
					adr_nxt = adr_r + 32'h4;
				end
			end
			S_END: begin
				st_nxt = S_IDLE;
				ev_e   = 1'b1;
			end
			default: st_nxt = S_IDLE;
		endcase
		// chained walks leave no single record to reuse
		if (st_r == S_WB && w_r[0][`ITC_R_CHN]) begin
			hold_nxt = 1'b0;
		end
		// request drops for one cycle after each ack
		req_nxt = !mem_ack && (st_nxt != S_IDLE) && (st_nxt != S_END);
		we_nxt  = (st_nxt == S_WR) || (st_nxt == S_WB);
		wd_nxt  = (st_nxt == S_WR) ? dat_nxt : w_nxt[wi_nxt];
	end

	// engine update
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			st_r   <= S_IDLE;
			vec_r  <= 8'h0;
			last_r <= 8'h0;
			hold_r <= 1'b0;
			cab_r  <= 1'b0;
			pend_r <= '0;
			rec_r  <= 32'h0;
			wi_r   <= 2'h0;
			bc_r   <= 8'h0;
			dat_r  <= 32'h0;
			req_r  <= 1'b0;
			we_r   <= 1'b0;
			adr_r  <= 32'h0;
			wd_r   <= 32'h0;
			for (int k = 0; k < 4; k++) begin
				w_r[k] <= 32'h0;
			end
		end else begin
			st_r   <= st_nxt;
			vec_r  <= vec_nxt;
			last_r <= last_nxt;
			hold_r <= hold_nxt;
			cab_r  <= cab_nxt;
			pend_r <= pend_nxt;
			rec_r  <= rec_nxt;
			wi_r   <= wi_nxt;
			bc_r   <= bc_nxt;
			dat_r  <= dat_nxt;
			req_r  <= req_nxt;
			we_r   <= we_nxt;
			adr_r  <= adr_nxt;
			wd_r   <= wd_nxt;
			for (int k = 0; k < 4; k++) begin
				w_r[k] <= w_nxt[k];
			end
		end
	end

	assign reg_rdata = rdat_r;
	assign mem_req   = req_r;
	assign mem_we    = we_r;
	assign mem_addr  = adr_r;
	assign mem_wdata = wd_r;
	assign irq       = irq_r;

	// ------------------------------
	// checks
	// ------------------------------
	sequence s_start;
		st_r == S_IDLE && ctrl_r[`ITC_C_CLK] && pick && !ctrl_r[`ITC_C_SEQ];
	endsequence
	property p_vec;
		@(posedge sys_clk) disable iff (!rstn)
		st_r == S_VEC |-> adr_r == vbr_r + {22'h0, vec_r, 2'h0};
	endproperty
	a_vec: assert property (p_vec) else $error("vector entry address wrong");
	property p_skip;
		@(posedge sys_clk) disable iff (!rstn)
		s_start ##0 (ctrl_r[`ITC_C_SKIP] && hold_r && last_r == pv) |=> st_r == S_RD;
	endproperty
	a_skip: assert property (p_skip) else $error("read skip not taken");
	property p_fetch;
		@(posedge sys_clk) disable iff (!rstn)
		s_start ##0 (last_r != pv) |=> st_r == S_VEC ##1 req_r;
	endproperty
	a_fetch: assert property (p_fetch) else $error("new vector not fetched");
	property p_stop;
		@(posedge sys_clk) disable iff (!rstn)
		st_r == S_IDLE && !ctrl_r[`ITC_C_CLK] |=> st_r == S_IDLE;
	endproperty
	a_stop: assert property (p_stop) else $error("ran with clock stopped");
	property p_seq;
		@(posedge sys_clk) disable iff (!rstn)
		st_r == S_SEQ |-> adr_r == ibr_r + {22'h0, seqn_r, 2'h0};
	endproperty
	a_seq: assert property (p_seq) else $error("index entry address wrong");
	property p_short;
		@(posedge sys_clk) disable iff (!rstn)
		shrt && $changed(st_r) && (st_r == S_RD || st_r == S_WR)
		|-> adr_r <= 32'h007fffff || adr_r >= 32'hff800000;
	endproperty
	a_short: assert property (p_short) else $error("short address out of range");
	property p_pend;
		@(posedge sys_clk) disable iff (!rstn)
		st_r != S_IDLE && pend_r[0] |=> pend_r[0];
	endproperty
	a_pend: assert property (p_pend) else $error("pending request lost");
	property p_busy;
		@(posedge sys_clk) disable iff (!rstn)
		reg_rd && reg_addr == `ITC_A_STAT |=> reg_rdata[31] == ($past(st_r) != S_IDLE);
	endproperty
	a_busy: assert property (p_busy) else $error("busy status wrong");
	property p_irq;
		@(posedge sys_clk) disable iff (!rstn)
		ev_x && imsk_r[0] |=> ist_r[0] ##1 irq_r;
	endproperty
	a_irq: assert property (p_irq) else $error("transfer interrupt missing");
endmodule // itc_top
`default_nettype wire

// ### itc_mem_model.sv
// itc_mem_model.sv: behavioural system memory on the controller's bus
// assumes one access at a time, held by the controller until acked
`timescale 1ns/1ps
`default_nettype none
module itc_mem_model (
	input  wire logic        sys_clk,   // system clock
	input  wire logic        rstn,      // sync reset, active low
	input  wire logic        mem_req,   // access request level
	input  wire logic        mem_we,    // write when high
	input  wire logic [31:0] mem_addr,  // byte address
	input  wire logic [31:0] mem_wdata, // write data
	input  wire logic [1:0]  lat,       // wait cycles before ack
	output logic      [31:0] mem_rdata, // read data, valid with ack only
	output logic             mem_ack    // one-cycle completion pulse
);
	logic [31:0] mem [logic [31:0]]; // sparse store, byte addressed
	logic [1:0]  wait_r;             // cycles waited so far
	// ------------------------------
	// answer after lat cycles
	// ------------------------------
	// data lines toggle outside ack so stale data never looks valid
	always @(posedge sys_clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (!rstn) begin
			wait_r <= 2'h0;
			mem_rdata <= 32'h5a5a_5a5a;
		end else if (mem_req && !mem_ack) begin
			if (wait_r >= lat) begin
				mem_ack <= 1'b1;
				wait_r <= 2'h0;
				if (mem_we)
					mem[mem_addr] = mem_wdata;
				else
					mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
			end else begin
				wait_r <= wait_r + 2'h1;
			end
		end
	end
endmodule // itc_mem_model
`default_nettype wire

// ### itc_top_tb_top.sv
// itc_top_tb_top.sv: self-checking bench of the transfer controller
// assumes itc_mem_model as memory, one 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "itc_cfg.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module itc_top_tb_top;
	localparam logic [31:0] VBR = 32'h0000_1000; // vector table base
	logic        sys_clk, rstn, reg_wr, reg_rd, mem_req, mem_we, mem_ack, irq;
	logic [7:0]  reg_addr, act_req;
	logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata;
	logic [1:0]  lat;                   // memory wait cycles
	logic [31:0] seed = 32'hea762b12;   // lfsr state
	logic [31:0] d, s0, s1;             // read data, source data
	logic [2:0]  v;                     // random source
	logic [31:0] rlog [$];              // read addresses seen
	int          bad_count = 0, total_checks = 0;
	itc_top i_itc_top (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.act_req(act_req), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq(irq));
	itc_mem_model i_itc_mem_model (.sys_clk(sys_clk), .rstn(rstn), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .lat(lat),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack));
	// ------------------------------
	// helpers
	// ------------------------------
	function automatic logic [31:0] lfsr();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	// record word 0, both increments on
	function automatic logic [31:0] w0(input logic [1:0] m, input logic chn, input logic each,
		input logic [7:0] sz, input logic [15:0] cnt);
		return {cnt, sz, 2'b00, 1'b1, 1'b1, each, chn, m};
	endfunction
	task automatic put(input logic [31:0] a, input logic [31:0] x);
		i_itc_mem_model.mem[a] = x;
	endtask
	// vector entry (v >= 0) and record words; short records have no word 3
	task automatic rec(input int sv, input logic [31:0] ra, input logic [31:0] w,
		input logic [31:0] sa, input logic [31:0] da, input logic sh);
		if (sv >= 0) put(VBR + 32'(4 * sv), ra);
		put(ra, w);
		put(ra + 32'h4, sa);
		put(ra + 32'h8, da);
		if (!sh) put(ra + 32'hc, {24'h0, w[15:8]});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= x;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] x);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 x = reg_rdata;
	endtask
	task automatic pulse(input logic [7:0] m);
		rlog.delete();
		@(posedge sys_clk);
		act_req <= m;
		lat <= 2'(lfsr());
		@(posedge sys_clk);
		act_req <= 8'h00;
	endtask
	// polls busy twice so a gap between served sources is not taken for the end
	task automatic idle();
		repeat (2) begin
			repeat (4) @(posedge sys_clk);
			d = 32'h8000_0000;
			for (int i = 0; i < 300 && d[31] !== 1'b0; i++) rd(`ITC_A_STAT, d);
		end
		`CHK(d[31], 1'b0)
	endtask
	task automatic fire(input logic [7:0] m);
		pulse(m);
		idle();
	endtask
	task automatic end_of_test();
		if (bad_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ------------------------------
	// clock, watchdog, read log
	// ------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (60000) @(posedge sys_clk);
		bad_count++;
		end_of_test();
	end
	always @(posedge sys_clk) if (mem_ack && !mem_we) rlog.push_back(mem_addr);
	// ------------------------------
	// scenarios
	// ------------------------------
	initial begin
		rstn = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
		act_req = 8'h00; lat = 2'h0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		rd(`ITC_A_CTRL, d);
		`CHK(d[5:0], `ITC_RST_CTRL)
		rd(8'h20, d);
		`CHK(d, 32'h0)
		wr(`ITC_A_VBR, VBR | 32'h3ff);
		rd(`ITC_A_VBR, d);
		`CHK(d, VBR)
		wr(`ITC_A_IMSK, 32'h1);
		// module clock off: request waits, then served in full mode
		v = 3'(lfsr());
		s0 = lfsr();
		rec(v, 32'h4000, w0(`ITC_M_NORM, 1'b0, 1'b0, 8'h0, 16'h1), 32'hc000_0000, 32'h9000, 1'b0);
		put(32'hc000_0000, s0);
		wr(`ITC_A_EN, 32'hff);
		fire(8'h01 << v);
		`CHK(rlog.size(), 0)
		wr(`ITC_A_CTRL, 32'h1);
		idle();
		`CHK(rlog[0], VBR + 32'(4 * v))
		`CHK(rlog[1], 32'h4000)
		`CHK(rlog[5], 32'hc000_0000)
		`CHK(i_itc_mem_model.mem[32'h9000], s0)
		rd(`ITC_A_IST, d);
		`CHK(d[1:0], 2'h3)
		`CHK(irq, 1'b1)
		wr(`ITC_A_IMSK, 32'h0);
		repeat (2) @(posedge sys_clk);
		`CHK(irq, 1'b0)
		wr(`ITC_A_IMSK, 32'h1);
		wr(`ITC_A_IST, 32'h1);
		repeat (2) @(posedge sys_clk);
		`CHK(irq, 1'b0)
		rd(`ITC_A_EN, d);
		`CHK(d[v], 1'b0)
		fire(8'h01 << v);
		`CHK(rlog.size(), 0)
		// each mode once: normal with per-transfer irq, repeat, block of two
		wr(`ITC_A_EN, 32'hff);
		for (int m = 0; m < 3; m++) begin
			s0 = lfsr();
			s1 = lfsr();
			rec(m, 32'h5000 + 32'(m * 64), w0(2'(m), 1'b0, m == 0, 8'h02,
				(m == 0) ? 16'h2 : 16'h1), 32'h8000 + 32'(m * 16), 32'ha000 + 32'(m * 16), 1'b0);
			put(32'h8000 + 32'(m * 16), s0);
			put(32'h8004 + 32'(m * 16), s1);
			put(32'ha004 + 32'(m * 16), 32'h0);
			wr(`ITC_A_IST, 32'h3);
			fire(8'(1 << m));
			`CHK(i_itc_mem_model.mem[32'ha000 + 32'(m * 16)], s0)
			`CHK(i_itc_mem_model.mem[32'ha004 + 32'(m * 16)], (m == 2) ? s1 : 32'h0)
			rd(`ITC_A_IST, d);
			`CHK(d[0], m != 1)
			rd(`ITC_A_EN, d);
			`CHK(d[m], m != 2)
		end
		// read skip on same source, full fetch after another one
		wr(`ITC_A_CTRL, 32'h5);
		rec(6, 32'h6000, w0(`ITC_M_NORM, 1'b0, 1'b0, 8'h0, 16'h3), 32'h8100, 32'hb000, 1'b0);
		rec(7, 32'h6100, w0(`ITC_M_NORM, 1'b0, 1'b0, 8'h0, 16'h3), 32'h8200, 32'hb100, 1'b0);
		fire(8'h40);
		fire(8'h40);
		`CHK(rlog[0], 32'h8104)
		fire(8'h80);
		`CHK(rlog[0], VBR + 32'd28)
		fire(8'h40);
		`CHK(rlog[0], VBR + 32'd24)
		// two sources at once: lower index first, status shows it
		wr(`ITC_A_CTRL, 32'h1);
		rec(2, 32'h6200, w0(`ITC_M_NORM, 1'b0, 1'b0, 8'h0, 16'h1), 32'h8300, 32'hb200, 1'b0);
		rec(5, 32'h6300, w0(`ITC_M_NORM, 1'b0, 1'b0, 8'h0, 16'h1), 32'h8400, 32'hb300, 1'b0);
		s0 = lfsr();
		put(32'h8400, s0);
		wr(`ITC_A_EN, 32'hff);
		pulse(8'h24);
		repeat (2) @(posedge sys_clk);
		rd(`ITC_A_STAT, d);
		`CHK({d[31], d[7:0]}, 9'h102)
		idle();
		`CHK(rlog[0], VBR + 32'd8)
		`CHK(i_itc_mem_model.mem[32'hb300], s0)
		// chain of two records from one activation
		s0 = lfsr();
		s1 = lfsr();
		rec(1, 32'h6400, w0(`ITC_M_NORM, 1'b1, 1'b0, 8'h0, 16'h1), 32'h8500, 32'hb400, 1'b0);
		rec(-1, 32'h6410, w0(`ITC_M_NORM, 1'b0, 1'b0, 8'h0, 16'h1), 32'h8600, 32'hb500, 1'b0);
		put(32'h8500, s0);
		put(32'h8600, s1);
		fire(8'h02);
		`CHK(i_itc_mem_model.mem[32'hb400], s0)
		`CHK(i_itc_mem_model.mem[32'hb500], s1)
		// chain abort while the first record runs: the second is never moved
		rec(1, 32'h6400, w0(`ITC_M_NORM, 1'b1, 1'b0, 8'h0, 16'h1), 32'h8500, 32'hb800, 1'b0);
		put(32'h6418, 32'hb900);
		wr(`ITC_A_EN, 32'hff);
		pulse(8'h02);
		wr(`ITC_A_CTRL, 32'h11);
		idle();
		`CHK(i_itc_mem_model.mem[32'hb800], s0)
		`CHK(i_itc_mem_model.mem.exists(32'hb900), 0)
		// sequence: record found through the index table, not the vector
		wr(`ITC_A_IBR, 32'h2000);
		wr(`ITC_A_SEQ, 32'h3);
		wr(`ITC_A_CTRL, 32'h9);
		put(32'h200c, 32'h6500);
		rec(-1, 32'h6500, w0(`ITC_M_NORM, 1'b0, 1'b0, 8'h0, 16'h1), 32'h8700, 32'hb600, 1'b0);
		rec(4, 32'h6600, w0(`ITC_M_NORM, 1'b0, 1'b0, 8'h0, 16'h1), 32'h8700, 32'hb700, 1'b0);
		s0 = lfsr();
		put(32'h8700, s0);
		fire(8'h10);
		`CHK(i_itc_mem_model.mem[32'hb600], s0)
		wr(`ITC_A_CTRL, 32'h29);
		rd(`ITC_A_CTRL, d);
		`CHK(d[3], 1'b0)
		// short mode: three-word record, high range reached by sign extension
		wr(`ITC_A_CTRL, 32'h3);
		s0 = lfsr();
		rec(0, 32'h6700, w0(`ITC_M_NORM, 1'b0, 1'b0, 8'h0, 16'h1), 32'h00ff_f000, 32'hc000, 1'b1);
		put(32'hffff_f000, s0);
		wr(`ITC_A_EN, 32'hff);
		fire(8'h01);
		`CHK(rlog[4], 32'hffff_f000)
		`CHK(i_itc_mem_model.mem[32'hc000], s0)
		end_of_test();
	end
endmodule // itc_top_tb_top
`default_nettype wire
